// *** shared/sfr_bank_consts.vh ***
// Register word indices, reset values, write masks and field positions of the lower register bank
`ifndef SFR_BANK_CONSTS_VH
`define SFR_BANK_CONSTS_VH

// ==========================================================================
// Register indices (APB byte address is four times the index)
`define OFF_DATA_POINTER_LOW 8'h82
`define OFF_DATA_POINTER_HIGH 8'h83
`define OFF_CPU_CLOCK_DIVIDER 8'h95
`define OFF_ADC_CONTROL 8'h97
`define OFF_ADC_MODE_CLOCK 8'ha1
`define OFF_AUX_FUNCTION 8'ha2
`define OFF_ADC_INPUT_SELECT 8'ha3
`define OFF_CAPTURE_A_HIGH 8'hab
`define OFF_COMPARATOR_ONE_CTRL 8'hac
`define OFF_COMPARATOR_TWO_CTRL 8'had
`define OFF_BAUD_GEN_CTRL 8'hbd
`define OFF_BAUD_RATE_LOW 8'hbe
`define OFF_BAUD_RATE_HIGH 8'hbf
`define OFF_ADC_MODE_SCAN 8'hc0
`define OFF_TWOWIRE_CONTROL 8'hd8
`define OFF_TWOWIRE_STATUS 8'hd9
`define OFF_TWOWIRE_DATA 8'hda
`define OFF_TWOWIRE_OWN_ADDRESS 8'hdb
`define OFF_TWOWIRE_CLOCK_LOW 8'hdc
`define OFF_TWOWIRE_CLOCK_HIGH 8'hdd
`define OFF_ACCUMULATOR 8'he0
`define OFF_FLASH_CTRL_CMD 8'he4
`define OFF_FLASH_DATA 8'he5
`define OFF_FLASH_ADDRESS_LOW 8'he6
`define OFF_FLASH_ADDRESS_HIGH 8'he7
`define OFF_CAPCOMP_A_CTRL 8'hea
`define OFF_CAPCOMP_B_CTRL 8'heb
`define OFF_CAPCOMP_C_CTRL 8'hec
`define OFF_CAPCOMP_D_CTRL 8'hed
`define OFF_MULTIPLY_OPERAND 8'hf0
`define OFF_EEPROM_CONTROL 8'hf1
`define OFF_EEPROM_DATA 8'hf2
`define OFF_EEPROM_ADDRESS 8'hf3

// ==========================================================================
// Reset values
`define RST_ZERO 8'h00
`define RST_TWOWIRE_STATUS 8'hf8
`define RST_FLASH_CTRL_CMD 8'h70
`define RST_EEPROM_CONTROL 8'h0e

// ==========================================================================
// Writable bit masks
`define WM_FULL 8'hff
`define WM_ADC_MODE_CLOCK 8'he0
`define WM_AUX_FUNCTION 8'hf9
`define WM_COMPARATOR 8'h3d
`define WM_BAUD_GEN_CTRL 8'h03
`define WM_ADC_MODE_SCAN 8'hf0
`define WM_TWOWIRE_CONTROL 8'h7d
`define WM_CAPCOMP_CD 8'h07
`define WM_EEPROM_CONTROL 8'hf1

// ==========================================================================
// Field positions
`define AUX_CLOCK_LOW_POWER 7
`define AUX_BREAK_RESET_EN 6
`define AUX_TIMER1_TOGGLE 5
`define AUX_TIMER0_TOGGLE 4
`define AUX_SOFTWARE_RESET 3
`define AUX_POINTER_SELECT 0
`define ADC_DONE_FLAG 3
`define CMP_OUTPUT_BIT 1
`define CMP_FLAG_BIT 0
`define TWOWIRE_EVENT_FLAG 3
`define EEPROM_DONE_FLAG 7
`define EEPROM_HV_ERROR 6
`define EEPROM_ADDR_NINE 0
`define BAUD_SOURCE_SELECT 1
`define BAUD_GEN_ENABLE 0
`define FLASH_FIXED_ONES 8'h70

`endif

// *** hdl/sfr_cell.v ***
// One eight-bit register with masked byte write, optional bit write and hardware flag set
`timescale 1ns/1ns
`default_nettype none
module sfr_cell #(
	parameter [7:0] RESET = 8'h00,
	parameter [7:0] WMASK = 8'hff,
	parameter [7:0] BASE = 8'h00,
	parameter BIT_EN = 0
) (
	input wire clk,
	input wire rst_n,
	input wire wr_en,
	input wire [7:0] wdata,
	input wire bit_we,
	input wire [7:0] bit_addr,
	input wire bit_wdata,
	input wire [7:0] hw_set,
	output reg [7:0] q
);
	wire bit_hit;
	wire [7:0] bit_sel;
	assign bit_hit = (BIT_EN != 0) && bit_we && (bit_addr[7:3] == BASE[7:3]);
	assign bit_sel = (8'h01 << bit_addr[2:0]) & WMASK;
	// Hardware set is ORed last so a flag event beats a same-cycle clear
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= RESET;
		else if (wr_en)
			q <= (q & ~WMASK) | (wdata & WMASK) | hw_set; // R3 R4
		else if (bit_hit)
			q <= (q & ~bit_sel) | ({8{bit_wdata}} & bit_sel) | hw_set; // R6
		else
			q <= q | hw_set;
	end
endmodule // sfr_cell
`default_nettype wire

// *** hdl/ro_reg.v ***
// Read-only status holder loaded by its peripheral, never by software
`timescale 1ns/1ns
`default_nettype none
module ro_reg #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
	input wire clk,
	input wire rst_n,
	input wire load,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] q
);
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= RESET;
		else if (load)
			q <= din; // R15
	end
endmodule // ro_reg
`default_nettype wire

// *** hdl/sfr_bank.v ***
// APB register bank for the lower special function register range of an 8-bit controller
// ==========================================================================
// Function
// R1: Software never touches an address of the bank that is not defined.
// R2: Software uses each register only for its own purpose, not as storage.
// R3: Reserved bits are written as zero and may read back as any value.
// R4: Fixed-zero bits are written as zero and always read as zero.
// R5: Fixed-one bits are written as one and always read as one.
// R6: Accumulator, multiply operand and two-wire control are bit addressable at register address plus bit index.
// R7: Capture-compare A and B hold event field, edge select, filter, force output and compare mode, reset zero.
// R8: Capture-compare C and D hold only force output at bit 2 and compare mode at bits 1:0.
// R9: Baud generator takes a 16-bit rate from low and high bytes; control has source select and enable.
// R10: Aux function holds low power, break reset, timer toggles, software reset, fixed zero and pointer select.
// R11: Each comparator control holds enable, inputs, output enable, output and flag in bits 5 to 0.
// R12: EEPROM has data and low address bytes; the ninth address bit sits in control bit 0, reset 0e.
// R13: Capture A high byte resets to zero and reads at its own address.
// R14: Flash control reads busy and status, while a write there is taken as an eight-bit command.
// R15: Writes to read-only status registers are ignored; the peripheral value stays.
`timescale 1ns/1ns
`default_nettype none
`include "sfr_bank_consts.vh"
module sfr_bank #(
	parameter NREG = 30
) (
	input wire clk,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Core bit access
	input wire [7:0] bit_addr,
	input wire bit_we,
	input wire bit_wdata,
	output wire bit_rdata,
	// Peripheral status
	input wire adc_done_set,
	input wire cmp_one_out,
	input wire cmp_one_flag_set,
	input wire cmp_two_out,
	input wire cmp_two_flag_set,
	input wire twowire_event_set,
	input wire twowire_status_load,
	input wire [4:0] twowire_status_in,
	input wire capture_a_load,
	input wire [7:0] capture_a_in,
	input wire eeprom_done_set,
	input wire eeprom_hv_error_set,
	input wire flash_busy,
	input wire [3:0] flash_flags,
	// Control outputs
	output wire [15:0] data_pointer,
	output wire pointer_select_bit,
	output wire clock_low_power_bit,
	output wire break_reset_enable,
	output wire [1:0] timer_toggle_enable,
	output wire software_reset_pulse,
	output wire [7:0] cpu_clock_divider,
	output wire [15:0] baud_rate,
	output wire baud_gen_enable,
	output wire baud_source_select,
	output wire [7:0] capcomp_a_ctrl,
	output wire [7:0] capcomp_b_ctrl,
	output wire [2:0] capcomp_c_ctrl,
	output wire [2:0] capcomp_d_ctrl,
	output wire [5:2] comparator_one_ctrl,
	output wire [5:2] comparator_two_ctrl,
	output wire [7:0] twowire_control,
	output wire [8:0] eeprom_address,
	output wire [7:0] flash_cmd,
	output wire flash_cmd_valid
);

	// ==========================================================================
	// Register table: {bit addressable, index, reset, write mask}
	function [24:0] cfg;
		input integer k;
		begin
			case (k)
				0: cfg = {1'b0, `OFF_DATA_POINTER_LOW, `RST_ZERO, `WM_FULL};
				1: cfg = {1'b0, `OFF_DATA_POINTER_HIGH, `RST_ZERO, `WM_FULL};
				2: cfg = {1'b0, `OFF_CPU_CLOCK_DIVIDER, `RST_ZERO, `WM_FULL};
				3: cfg = {1'b0, `OFF_ADC_CONTROL, `RST_ZERO, `WM_FULL};
				4: cfg = {1'b0, `OFF_ADC_MODE_CLOCK, `RST_ZERO, `WM_ADC_MODE_CLOCK};
				5: cfg = {1'b0, `OFF_AUX_FUNCTION, `RST_ZERO, `WM_AUX_FUNCTION}; // R10
				6: cfg = {1'b0, `OFF_ADC_INPUT_SELECT, `RST_ZERO, `WM_FULL};
				7: cfg = {1'b0, `OFF_COMPARATOR_ONE_CTRL, `RST_ZERO, `WM_COMPARATOR}; // R11
				8: cfg = {1'b0, `OFF_COMPARATOR_TWO_CTRL, `RST_ZERO, `WM_COMPARATOR}; // R11
				9: cfg = {1'b0, `OFF_BAUD_GEN_CTRL, `RST_ZERO, `WM_BAUD_GEN_CTRL}; // R9
				10: cfg = {1'b0, `OFF_BAUD_RATE_LOW, `RST_ZERO, `WM_FULL}; // R9
				11: cfg = {1'b0, `OFF_BAUD_RATE_HIGH, `RST_ZERO, `WM_FULL}; // R9
				12: cfg = {1'b0, `OFF_ADC_MODE_SCAN, `RST_ZERO, `WM_ADC_MODE_SCAN};
				13: cfg = {1'b1, `OFF_TWOWIRE_CONTROL, `RST_ZERO, `WM_TWOWIRE_CONTROL}; // R6
				14: cfg = {1'b0, `OFF_TWOWIRE_DATA, `RST_ZERO, `WM_FULL};
				15: cfg = {1'b0, `OFF_TWOWIRE_OWN_ADDRESS, `RST_ZERO, `WM_FULL};
				16: cfg = {1'b0, `OFF_TWOWIRE_CLOCK_LOW, `RST_ZERO, `WM_FULL};
				17: cfg = {1'b0, `OFF_TWOWIRE_CLOCK_HIGH, `RST_ZERO, `WM_FULL};
				18: cfg = {1'b1, `OFF_ACCUMULATOR, `RST_ZERO, `WM_FULL}; // R6
				19: cfg = {1'b0, `OFF_FLASH_DATA, `RST_ZERO, `WM_FULL};
				20: cfg = {1'b0, `OFF_FLASH_ADDRESS_LOW, `RST_ZERO, `WM_FULL};
				21: cfg = {1'b0, `OFF_FLASH_ADDRESS_HIGH, `RST_ZERO, `WM_FULL};
				22: cfg = {1'b0, `OFF_CAPCOMP_A_CTRL, `RST_ZERO, `WM_FULL}; // R7
				23: cfg = {1'b0, `OFF_CAPCOMP_B_CTRL, `RST_ZERO, `WM_FULL}; // R7
				24: cfg = {1'b0, `OFF_CAPCOMP_C_CTRL, `RST_ZERO, `WM_CAPCOMP_CD}; // R8
				25: cfg = {1'b0, `OFF_CAPCOMP_D_CTRL, `RST_ZERO, `WM_CAPCOMP_CD}; // R8
				26: cfg = {1'b1, `OFF_MULTIPLY_OPERAND, `RST_ZERO, `WM_FULL}; // R6
				27: cfg = {1'b0, `OFF_EEPROM_CONTROL, `RST_EEPROM_CONTROL, `WM_EEPROM_CONTROL}; // R12
				28: cfg = {1'b0, `OFF_EEPROM_DATA, `RST_ZERO, `WM_FULL}; // R12
				29: cfg = {1'b0, `OFF_EEPROM_ADDRESS, `RST_ZERO, `WM_FULL}; // R12
				default: cfg = {1'b0, 8'h00, `RST_ZERO, 8'h00};
			endcase
		end
	endfunction

	// ==========================================================================
	// APB decode
	wire setup_phase;
	wire access_phase;
	wire word_aligned;
	wire [7:0] reg_index;
	wire hit_status;
	wire hit_capture;
	wire hit_flash;
	wire [NREG-1:0] hit;
	wire any_hit;
	wire wr_access;

	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign word_aligned = (paddr[1:0] == 2'b00);
	assign reg_index = paddr[9:2];
	assign hit_status = word_aligned && (reg_index == `OFF_TWOWIRE_STATUS);
	assign hit_capture = word_aligned && (reg_index == `OFF_CAPTURE_A_HIGH); // R13
	assign hit_flash = word_aligned && (reg_index == `OFF_FLASH_CTRL_CMD);
	assign any_hit = (|hit) || hit_status || hit_capture || hit_flash;
	assign wr_access = access_phase && pwrite;

	// Zero wait states; read data is captured in the setup cycle
	assign pready = access_phase;

	// ==========================================================================
	// Hardware flag sources per register
	wire [8*NREG-1:0] hw_set_bus;
	wire [8*NREG-1:0] q_bus;

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1)
		begin : cells
			localparam [24:0] C = cfg(g);
			reg [7:0] set_v;
			assign hit[g] = word_aligned && (reg_index == C[23:16]);
			always @*
			begin
				set_v = 8'h00;
				case (C[23:16])
					`OFF_ADC_CONTROL:
						set_v[`ADC_DONE_FLAG] = adc_done_set;
					`OFF_COMPARATOR_ONE_CTRL:
						set_v[`CMP_FLAG_BIT] = cmp_one_flag_set; // R11
					`OFF_COMPARATOR_TWO_CTRL:
						set_v[`CMP_FLAG_BIT] = cmp_two_flag_set; // R11
					`OFF_TWOWIRE_CONTROL:
						set_v[`TWOWIRE_EVENT_FLAG] = twowire_event_set;
					`OFF_EEPROM_CONTROL:
					begin
						set_v[`EEPROM_DONE_FLAG] = eeprom_done_set;
						set_v[`EEPROM_HV_ERROR] = eeprom_hv_error_set;
					end
					default:
						set_v = 8'h00;
				endcase
			end
			assign hw_set_bus[8*g+7:8*g] = set_v;
			sfr_cell #(
				.RESET(C[15:8]),
				.WMASK(C[7:0]),
				.BASE(C[23:16]),
				.BIT_EN(C[24])
			) u_cell (
				.clk(clk),
				.rst_n(rst_n),
				.wr_en(wr_access && hit[g]),
				.wdata(pwdata[7:0]),
				.bit_we(bit_we),
				.bit_addr(bit_addr),
				.bit_wdata(bit_wdata),
				.hw_set(hw_set_bus[8*g+7:8*g]),
				.q(q_bus[8*g+7:8*g])
			);
		end
	endgenerate

	// ==========================================================================
	// Peripheral-owned registers
	wire [4:0] status_q;
	wire [7:0] capture_q;

	ro_reg #(
		.WIDTH(5),
		.RESET(5'h1f)
	) u_twowire_status (
		.clk(clk),
		.rst_n(rst_n),
		.load(twowire_status_load),
		.din(twowire_status_in),
		.q(status_q)
	); // R15

	ro_reg #(
		.WIDTH(8),
		.RESET(`RST_ZERO)
	) u_capture_a_high (
		.clk(clk),
		.rst_n(rst_n),
		.load(capture_a_load),
		.din(capture_a_in),
		.q(capture_q)
	); // R13

	// ==========================================================================
	// Read path
	reg [7:0] rd_byte;
	reg [7:0] prdata_reg;
	reg unmapped_reg;
	integer i;

	always @*
	begin
		rd_byte = 8'h00;
		for (i = 0; i < NREG; i = i + 1)
		begin
			if (hit[i])
				rd_byte = q_bus[8*i +: 8];
		end
		// Comparator outputs read live from the analog side
		if (hit[7])
			rd_byte[`CMP_OUTPUT_BIT] = cmp_one_out; // R11
		if (hit[8])
			rd_byte[`CMP_OUTPUT_BIT] = cmp_two_out; // R11
		if (hit_status)
			rd_byte = {status_q, 3'b000}; // R4
		if (hit_capture)
			rd_byte = capture_q; // R13
		if (hit_flash)
			rd_byte = {flash_busy, 3'b000, flash_flags} | `FLASH_FIXED_ONES; // R5 R14
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_reg <= 8'h00;
			unmapped_reg <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata_reg <= pwrite ? 8'h00 : rd_byte;
			unmapped_reg <= !any_hit; // R1
		end
	end

	assign prdata = {24'h000000, prdata_reg};
	assign pslverr = access_phase && unmapped_reg; // R1

	// ==========================================================================
	// Bit read path for the bit-addressable registers
	reg bit_rdata_reg;
	reg [7:0] bit_src;

	always @*
	begin
		case ({3'b000, bit_addr[7:3]})
			`OFF_ACCUMULATOR >> 3:
				bit_src = q_bus[8*18 +: 8]; // R6
			`OFF_MULTIPLY_OPERAND >> 3:
				bit_src = q_bus[8*26 +: 8]; // R6
			`OFF_TWOWIRE_CONTROL >> 3:
				bit_src = q_bus[8*13 +: 8]; // R6
			default:
				bit_src = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bit_rdata_reg <= 1'b0;
		else
			bit_rdata_reg <= bit_src[bit_addr[2:0]];
	end

	assign bit_rdata = bit_rdata_reg;

	// ==========================================================================
	// Flash command port and software reset pulse
	reg [7:0] flash_cmd_reg;
	reg flash_cmd_valid_reg;
	reg software_reset_reg;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_cmd_reg <= 8'h00;
			flash_cmd_valid_reg <= 1'b0;
			software_reset_reg <= 1'b0;
		end
		else
		begin
			flash_cmd_valid_reg <= wr_access && hit_flash; // R14
			if (wr_access && hit_flash)
				flash_cmd_reg <= pwdata[7:0]; // R14
			// Pulse only; the stored bit does not hold the reset on
			software_reset_reg <= wr_access && hit[5] && pwdata[`AUX_SOFTWARE_RESET]; // R10
		end
	end

	assign flash_cmd = flash_cmd_reg;
	assign flash_cmd_valid = flash_cmd_valid_reg;
	assign software_reset_pulse = software_reset_reg;

	// ==========================================================================
	// Control outputs
	wire [7:0] aux_q;
	wire [7:0] brg_ctrl_q;
	wire [7:0] eeprom_ctrl_q;

	assign aux_q = q_bus[8*5 +: 8];
	assign brg_ctrl_q = q_bus[8*9 +: 8];
	assign eeprom_ctrl_q = q_bus[8*27 +: 8];

	assign data_pointer = {q_bus[8*1 +: 8], q_bus[8*0 +: 8]};
	assign cpu_clock_divider = q_bus[8*2 +: 8];
	assign pointer_select_bit = aux_q[`AUX_POINTER_SELECT]; // R10
	assign clock_low_power_bit = aux_q[`AUX_CLOCK_LOW_POWER]; // R10
	assign break_reset_enable = aux_q[`AUX_BREAK_RESET_EN]; // R10
	assign timer_toggle_enable = {aux_q[`AUX_TIMER1_TOGGLE], aux_q[`AUX_TIMER0_TOGGLE]}; // R10
	assign baud_rate = {q_bus[8*11 +: 8], q_bus[8*10 +: 8]}; // R9
	assign baud_gen_enable = brg_ctrl_q[`BAUD_GEN_ENABLE]; // R9
	assign baud_source_select = brg_ctrl_q[`BAUD_SOURCE_SELECT]; // R9
	assign capcomp_a_ctrl = q_bus[8*22 +: 8]; // R7
	assign capcomp_b_ctrl = q_bus[8*23 +: 8]; // R7
	assign capcomp_c_ctrl = q_bus[8*24 +: 3]; // R8
	assign capcomp_d_ctrl = q_bus[8*25 +: 3]; // R8
	assign comparator_one_ctrl = q_bus[8*7+2 +: 4]; // R11
	assign comparator_two_ctrl = q_bus[8*8+2 +: 4]; // R11
	assign twowire_control = q_bus[8*13 +: 8];
	assign eeprom_address = {eeprom_ctrl_q[`EEPROM_ADDR_NINE], q_bus[8*29 +: 8]}; // R12

endmodule // sfr_bank
`default_nettype wire

// *** verification/sfr_bank_monitor.sv ***
// Concurrent checks on the ports of the lower register bank
`timescale 1ns/1ns
`default_nettype none
module sfr_bank_monitor (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [7:0] bit_addr,
	input wire bit_we,
	input wire bit_wdata,
	input wire flash_busy,
	input wire [3:0] flash_flags,
	input wire software_reset_pulse,
	input wire [15:0] baud_rate,
	input wire [2:0] capcomp_c_ctrl,
	input wire [7:0] twowire_control,
	input wire [8:0] eeprom_address,
	input wire [7:0] flash_cmd,
	input wire flash_cmd_valid
);
	// ==========================================================================
	// Access decode
	wire wr;
	wire rd;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================================
	// Properties
	chk_unaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unaligned access not refused");
	chk_flash_cmd: assert property (wr && paddr == 10'h390 |=> flash_cmd_valid && flash_cmd == $past(pwdata[7:0]))
		else $error("flash command not forwarded");
	chk_flash_read: assert property (rd && paddr == 10'h390 |-> prdata[7:0] == {$past(flash_busy), 3'h7, $past(flash_flags)})
		else $error("flash status read wrong");
	chk_aux_zero: assert property (rd && paddr == 10'h288 |-> prdata[2] == 1'b0)
		else $error("aux fixed zero bit read as one");
	chk_status_zero: assert property (rd && paddr == 10'h364 |-> prdata[2:0] == 3'h0)
		else $error("status low bits not zero");
	chk_soft_reset: assert property (wr && paddr == 10'h288 && pwdata[3] |=> software_reset_pulse ##1 !software_reset_pulse)
		else $error("software reset pulse wrong");
	chk_eeprom_addr: assert property (wr && paddr == 10'h3c4 |=> eeprom_address[8] == $past(pwdata[0]))
		else $error("ninth eeprom address bit wrong");
	chk_baud_high: assert property (wr && paddr == 10'h2fc |=> baud_rate[15:8] == $past(pwdata[7:0]))
		else $error("baud rate high byte wrong");
	chk_capcomp_c: assert property (wr && paddr == 10'h3b0 |=> capcomp_c_ctrl == $past(pwdata[2:0]))
		else $error("capture compare c control wrong");
	chk_bit_write: assert property (bit_we && bit_addr[7:3] == 5'h1b && bit_addr[2:0] != 3'h7 && bit_addr[2:0] != 3'h1
		&& bit_addr[2:0] != 3'h3 && !(wr && paddr == 10'h360)
		|=> twowire_control[$past(bit_addr[2:0])] == $past(bit_wdata))
		else $error("two-wire control bit write lost");
endmodule // sfr_bank_monitor

bind sfr_bank sfr_bank_monitor sfr_bank_monitor_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pslverr, .bit_addr, .bit_we, .bit_wdata, .flash_busy, .flash_flags, .software_reset_pulse, .baud_rate,
	.capcomp_c_ctrl, .twowire_control, .eeprom_address, .flash_cmd, .flash_cmd_valid);
`default_nettype wire

// *** verification/sfr_bank_tb.sv ***
// Self-checking bench for the lower register bank
`timescale 1ns/1ns
`default_nettype none
`include "sfr_bank_consts.vh"
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module sfr_bank_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] bit_addr = 8'h00;
	logic bit_we = 1'b0;
	logic bit_wdata = 1'b0;
	logic cmp_one_out = 1'b0;
	logic cmp_two_out = 1'b0;
	logic status_load = 1'b0;
	logic capture_load = 1'b0;
	logic flash_busy = 1'b0;
	logic [5:0] sets = 6'h00;
	logic [4:0] status_in = 5'h00;
	logic [7:0] capture_in = 8'h00;
	logic [3:0] flash_flags = 4'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	int fail_count = 0;
	int num_checks = 0;
	logic [32:0] expq[$];
	logic [32:0] exp_note;
	logic [7:0] lfsr = 8'h12;
	logic [7:0] r;
	logic [7:0] d;
	logic [7:0] wr_val[256];
	logic bit_rd = 1'b0;
	logic bit_rd_d = 1'b0;
	logic bit_note;
	logic bitq[$];
	logic [57:0] outs_exp;
	wire [57:0] outs;
	wire bit_rdata;
	logic [7:0] bases[3] = '{8'he0, 8'hf0, 8'hd8};
	logic [7:0] regs[33] = '{8'h82, 8'h83, 8'h95, 8'h97, 8'ha1, 8'ha2, 8'ha3, 8'hab, 8'hac, 8'had, 8'hbd,
		8'hbe, 8'hbf, 8'hc0, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'he0, 8'he4, 8'he5, 8'he6, 8'he7,
		8'hea, 8'heb, 8'hec, 8'hed, 8'hf0, 8'hf1, 8'hf2, 8'hf3};

	sfr_bank sfr_bank_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bit_addr(bit_addr), .bit_we(bit_we), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
		.adc_done_set(sets[0]), .cmp_one_out(cmp_one_out), .cmp_one_flag_set(sets[1]),
		.cmp_two_out(cmp_two_out), .cmp_two_flag_set(sets[2]), .twowire_event_set(sets[3]),
		.twowire_status_load(status_load), .twowire_status_in(status_in), .capture_a_load(capture_load),
		.capture_a_in(capture_in), .eeprom_done_set(sets[4]), .eeprom_hv_error_set(sets[5]),
		.flash_busy(flash_busy), .flash_flags(flash_flags), .data_pointer(outs[15:0]),
		.pointer_select_bit(outs[24]), .clock_low_power_bit(outs[25]), .break_reset_enable(outs[26]),
		.timer_toggle_enable(outs[28:27]), .software_reset_pulse(), .cpu_clock_divider(outs[23:16]),
		.baud_rate(), .baud_gen_enable(outs[29]), .baud_source_select(outs[30]), .capcomp_a_ctrl(outs[38:31]),
		.capcomp_b_ctrl(outs[46:39]), .capcomp_c_ctrl(), .capcomp_d_ctrl(outs[49:47]),
		.comparator_one_ctrl(outs[53:50]), .comparator_two_ctrl(outs[57:54]), .twowire_control(),
		.eeprom_address(), .flash_cmd(), .flash_cmd_valid());

	always #2 clk = ~clk;

	// ==========================================================================
	// Helpers
	function automatic logic [7:0] next_rand();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	function automatic logic [7:0] rst_val(input logic [7:0] i);
		case (i)
			8'hd9: return `RST_TWOWIRE_STATUS;
			8'he4: return `RST_FLASH_CTRL_CMD;
			8'hf1: return `RST_EEPROM_CONTROL;
			default: return `RST_ZERO;
		endcase
	endfunction

	function automatic logic [7:0] wmask(input logic [7:0] i);
		case (i)
			8'ha1: return `WM_ADC_MODE_CLOCK;
			8'ha2: return `WM_AUX_FUNCTION;
			8'hac, 8'had: return `WM_COMPARATOR;
			8'hbd: return `WM_BAUD_GEN_CTRL;
			8'hc0: return `WM_ADC_MODE_SCAN;
			8'hd8: return `WM_TWOWIRE_CONTROL;
			8'hec, 8'hed: return `WM_CAPCOMP_CD;
			8'hf1: return `WM_EEPROM_CONTROL;
			8'hab, 8'hd9, 8'he4: return 8'h00;
			default: return `WM_FULL;
		endcase
	endfunction

	// Leaves psel high so a following transfer goes back to back
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		expq.push_back({1'b0, 24'h0, e});
		apb(1'b0, {i, 2'h0}, 8'h00);
	endtask

	task automatic check_resets();
		foreach (regs[k]) rd(regs[k], rst_val(regs[k]));
	endtask

	task automatic end_of_test();
		if (expq.size() != 0 || bitq.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================================================
	// Read result watcher
	always @(posedge clk)
	begin
		if (psel && penable && !pwrite && pready === 1'b1)
		begin
			exp_note = expq.pop_front();
			`CHECK({pslverr, prdata}, exp_note)
		end
	end

	// Bit read data stands one edge after its address was sampled
	always @(posedge clk)
	begin
		bit_rd_d <= bit_rd;
		if (bit_rd_d)
		begin
			bit_note = bitq.pop_front();
			`CHECK(bit_rdata, bit_note)
		end
	end

	initial
	begin
		#100000;
		fail_count++;
		end_of_test();
	end

	// ==========================================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_resets();
		expq.push_back({1'b1, 32'h0});
		apb(1'b0, {8'h84, 2'h0}, 8'h00);
		expq.push_back({1'b1, 32'h0});
		apb(1'b0, 10'h209, 8'h00);
		apb(1'b1, 10'h20a, 8'hff);
		rd(8'h82, 8'h00);
		psel <= 1'b0;
		r = next_rand();
		sets <= 6'h3f;
		status_load <= 1'b1;
		status_in <= r[4:0];
		capture_load <= 1'b1;
		capture_in <= ~r;
		cmp_one_out <= 1'b1;
		cmp_two_out <= 1'b1;
		flash_busy <= 1'b1;
		flash_flags <= r[3:0];
		@(posedge clk);
		sets <= 6'h00;
		status_load <= 1'b0;
		capture_load <= 1'b0;
		rd(8'h97, 8'h08);
		rd(8'hac, 8'h03);
		rd(8'had, 8'h03);
		rd(8'hd8, 8'h08);
		rd(8'hf1, 8'hce);
		rd(8'he4, {4'hf, r[3:0]});
		apb(1'b1, {8'hd9, 2'h0}, 8'hff);
		apb(1'b1, {8'hab, 2'h0}, r);
		rd(8'hd9, {r[4:0], 3'h0});
		rd(8'hab, ~r);
		psel <= 1'b0;
		cmp_one_out <= 1'b0;
		cmp_two_out <= 1'b0;
		flash_busy <= 1'b0;
		flash_flags <= 4'h0;
		@(posedge clk);
		// Random write and read back of every register but two-wire status and capture A high, reserved bits written as zero except at flash control
		foreach (regs[k])
		begin
			if (regs[k] == 8'hd9 || regs[k] == 8'hab) continue;
			r = next_rand();
			d = (regs[k] == 8'he4) ? r : (r & wmask(regs[k]));
			wr_val[regs[k]] = d;
			apb(1'b1, {regs[k], 2'h0}, d);
			rd(regs[k], (d & wmask(regs[k])) | (rst_val(regs[k]) & ~wmask(regs[k])));
		end
		outs_exp = {wr_val[8'had][5:2], wr_val[8'hac][5:2], wr_val[8'hed][2:0], wr_val[8'heb], wr_val[8'hea],
			wr_val[8'hbd][1:0], wr_val[8'ha2][5:4], wr_val[8'ha2][6], wr_val[8'ha2][7], wr_val[8'ha2][0],
			wr_val[8'h95], wr_val[8'h83], wr_val[8'h82]};
		`CHECK(outs, outs_exp)
		// Directed software reset so the pulse check sees a trigger
		apb(1'b1, {8'ha2, 2'h0}, 8'h08);
		rd(8'ha2, 8'h08);
		foreach (bases[j])
		begin
			apb(1'b1, {bases[j], 2'h0}, 8'h00);
			psel <= 1'b0;
			r = next_rand();
			for (int k = 0; k < 8; k++)
			begin
				bit_we <= 1'b1;
				bit_addr <= bases[j] + 8'(k);
				bit_wdata <= r[k];
				@(posedge clk);
			end
			bit_we <= 1'b0;
			d = r & wmask(bases[j]);
			for (int k = 0; k < 8; k++)
			begin
				bit_rd <= 1'b1;
				bit_addr <= bases[j] + 8'(k);
				bitq.push_back(d[k]);
				@(posedge clk);
			end
			bit_rd <= 1'b0;
			rd(bases[j], d);
		end
		psel <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_resets();
		psel <= 1'b0;
		@(posedge clk);
		end_of_test();
	end
endmodule // sfr_bank_tb
`default_nettype wire
